// ### rtl/dmiu_pkg.sv
package dmiu_pkg;
   // widths
   localparam int AXI_AW   = 8;
   localparam int AXI_DW   = 32;
   localparam int INST_W   = 14;
   localparam int PTR_W    = 16;
   localparam int BANK_W   = 5;
   localparam int PAGE_W   = 7;
   localparam int FILE_W   = 7;
   localparam int IDX_W    = 3;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] REG_ACC    = 3'h0;
   localparam logic [IDX_W-1:0] REG_STATUS = 3'h1;
   localparam logic [IDX_W-1:0] REG_BANK   = 3'h2;
   localparam logic [IDX_W-1:0] REG_PAGE   = 3'h3;
   localparam logic [IDX_W-1:0] REG_PTR0   = 3'h4;
   localparam logic [IDX_W-1:0] REG_PTR1   = 3'h5;
   localparam logic [IDX_W:0]   REG_COUNT  = 4'h6;
   // status register fields
   localparam int STAT_ZERO_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   // reset values
   localparam logic [7:0]        RST_ACC  = 8'h00;
   localparam logic [BANK_W-1:0] RST_BANK = 5'h00;
   localparam logic [PAGE_W-1:0] RST_PAGE = 7'h00;
   localparam logic [PTR_W-1:0]  RST_PTR  = 16'h0000;
   // opcode patterns on the fixed bits of each encoding
   localparam logic [6:0]  OP_STORE = 7'h01;   // bits 13:7
   localparam logic [8:0]  OP_BANK  = 9'h001;  // bits 13:5
   localparam logic [10:0] OP_IND   = 11'h002; // bits 13:3
   localparam logic [6:0]  OP_REL   = 7'h7e;   // bits 13:7
   localparam logic [5:0]  OP_LACC  = 6'h30;   // bits 13:8
   localparam logic [6:0]  OP_PAGE  = 7'h63;   // bits 13:7
   // pointer handling modes
   localparam logic [1:0] MODE_PRE_INC  = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC  = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;
   // file addresses that stand for the indirect data ports
   localparam logic [FILE_W-1:0] FILE_IND0 = 7'h00;
   localparam logic [FILE_W-1:0] FILE_IND1 = 7'h01;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### rtl/dmiu_reg_if.sv
interface dmiu_reg_if;
   import dmiu_pkg::*;
   logic              wr_en;
   logic [IDX_W-1:0]  wr_index;
   logic [AXI_DW-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic [IDX_W-1:0]  rd_index;
   logic [AXI_DW-1:0] rd_data;
   modport slave (output wr_en, wr_index, wr_data, wr_strb, rd_index, input rd_data);
   modport core (input wr_en, wr_index, wr_data, wr_strb, rd_index, output rd_data);
endinterface

// ### rtl/dmiu_axil_slave.sv
module dmiu_axil_slave
   import dmiu_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [AXI_DW-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [AXI_DW-1:0]        s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   dmiu_reg_if.slave                regs
);
   typedef struct packed {
      logic              aw_got;
      logic [IDX_W-1:0]  aw_idx;
      logic              aw_ok;
      logic              w_got;
      logic [AXI_DW-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [AXI_DW-1:0] rdata;
      logic [1:0]        rresp;
   } dmiu_axil_state_t;

   dmiu_axil_state_t s_reg, s_next;

   // an address is mapped when it lands on one of the low word slots
   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      return (a[AXI_AW-1:2] < {{(AXI_AW-2-IDX_W-1){1'b0}}, REG_COUNT});
   endfunction

   // a new address is refused while the previous answer waits
   assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
   assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
   assign s_axi_arready = !s_reg.rvalid;
   assign s_axi_bvalid  = s_reg.bvalid;
   assign s_axi_bresp   = s_reg.bresp;
   assign s_axi_rvalid  = s_reg.rvalid;
   assign s_axi_rdata   = s_reg.rdata;
   assign s_axi_rresp   = s_reg.rresp;
   assign regs.wr_en    = s_reg.aw_got && s_reg.w_got && s_reg.aw_ok;
   assign regs.wr_index = s_reg.aw_idx;
   assign regs.wr_data  = s_reg.wdata;
   assign regs.wr_strb  = s_reg.wstrb;
   assign regs.rd_index = s_axi_araddr[IDX_W+1:2];

   // channel bookkeeping; address and data are taken in either order
   always_comb
   begin
      s_next = s_reg;
      if (s_axi_awvalid && s_axi_awready)
      begin
         s_next.aw_got = 1'b1;
         s_next.aw_idx = s_axi_awaddr[IDX_W+1:2];
         s_next.aw_ok  = mapped(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         s_next.w_got = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (s_reg.aw_got && s_reg.w_got)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got  = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = s_reg.aw_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;
      if (s_reg.rvalid && s_axi_rready)
         s_next.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = mapped(s_axi_araddr) ? regs.rd_data : '0;
         s_next.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule

// ### rtl/dmiu_core.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
module dmiu_core
   import dmiu_pkg::*;
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [AXI_DW-1:0]   s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [AXI_DW-1:0]        s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                inst_valid,
   input  wire logic [INST_W-1:0]   inst_word,
   output logic                     inst_ready,
   output logic [PTR_W-1:0]         mem_addr,
   output logic                     mem_rd,
   output logic                     mem_wr,
   output logic [7:0]               mem_wdata,
   input  wire logic [7:0]          mem_rdata,
   input  wire logic                mem_rvalid,
   output logic [7:0]               acc_out,
   output logic                     zero_flag,
   output logic [BANK_W-1:0]        bank_sel,
   output logic [PAGE_W-1:0]        page_latch
);
   typedef struct packed {
      logic [7:0]             acc;
      logic                   zero;
      logic [BANK_W-1:0]      bank;
      logic [PAGE_W-1:0]      page;
      logic [1:0][PTR_W-1:0]  ptr;
      logic                   busy;
      logic [PTR_W-1:0]       addr;
      logic                   rd;
      logic                   wr;
      logic [7:0]             wdata;
   } dmiu_core_state_t;

   dmiu_core_state_t s_reg, s_next;
   dmiu_reg_if       regs ();

   logic             take;
   logic             is_store, is_bank, is_ind, is_rel, is_lacc, is_page;
   logic             ptr_sel;
   logic [1:0]       mode;
   logic [5:0]       offset;
   logic [PTR_W-1:0] ptr_cur, ptr_inc, ptr_dec, ptr_rel, ptr_ea, ptr_new;
   logic [FILE_W-1:0] file_addr;

   dmiu_axil_slave u_slave (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .regs          (regs.slave)
   );

   // byte-lane merge of a software write into a narrow register
   function automatic logic [PTR_W-1:0] merge(input logic [PTR_W-1:0] old,
                                              input logic [AXI_DW-1:0] d,
                                              input logic [3:0] strb);
      logic [PTR_W-1:0] r;
      r = old;
      if (strb[0])
         r[7:0] = d[7:0];
      if (strb[1])
         r[15:8] = d[15:8];
      return r;
   endfunction

   // decode looks only at the fixed opcode bits, never at literal bits
   assign is_store = (inst_word[13:7] == OP_STORE);
   assign is_bank  = (inst_word[13:5] == OP_BANK);
   assign is_ind   = (inst_word[13:3] == OP_IND);
   assign is_rel   = (inst_word[13:7] == OP_REL);
   assign is_lacc  = (inst_word[13:8] == OP_LACC);
   assign is_page  = (inst_word[13:7] == OP_PAGE);
   // a load holds the decoder until the data memory answers
   assign inst_ready = !s_reg.busy;
   assign take       = inst_valid && inst_ready;

   // pointer arithmetic; sixteen-bit sums drop the carry so they wrap
   assign ptr_sel   = is_ind ? inst_word[2] : inst_word[6];
   assign mode      = inst_word[1:0];
   assign offset    = inst_word[5:0];
   assign file_addr = inst_word[6:0];
   assign ptr_cur   = s_reg.ptr[ptr_sel];
   assign ptr_inc   = ptr_cur + 16'h0001;
   assign ptr_dec   = ptr_cur - 16'h0001;
   assign ptr_rel   = ptr_cur + {{(PTR_W-6){offset[5]}}, offset};

   // effective address and updated pointer for each mode
   always_comb
   begin
      ptr_ea  = ptr_cur;
      ptr_new = ptr_cur;
      if (is_rel)
         ptr_ea = ptr_rel;
      else
      begin
         unique case (mode)
            MODE_PRE_INC:  ptr_ea = ptr_inc;
            MODE_PRE_DEC:  ptr_ea = ptr_dec;
            MODE_POST_INC: ptr_ea = ptr_cur;
            MODE_POST_DEC: ptr_ea = ptr_cur;
         endcase
         ptr_new = mode[0] ? ptr_dec : ptr_inc;
      end
   end

   // register read view for the bus
   always_comb
   begin
      regs.rd_data = '0;
      unique case (regs.rd_index)
         REG_ACC:    regs.rd_data[7:0] = s_reg.acc;
         REG_STATUS:
         begin
            regs.rd_data[STAT_ZERO_BIT] = s_reg.zero;
            regs.rd_data[STAT_BUSY_BIT] = s_reg.busy;
         end
         REG_BANK:   regs.rd_data[BANK_W-1:0] = s_reg.bank;
         REG_PAGE:   regs.rd_data[PAGE_W-1:0] = s_reg.page;
         REG_PTR0:   regs.rd_data[PTR_W-1:0]  = s_reg.ptr[0];
         REG_PTR1:   regs.rd_data[PTR_W-1:0]  = s_reg.ptr[1];
         default:    regs.rd_data = '0;
      endcase
   end

   // instruction execution; memory strobes last one cycle
   always_comb
   begin
      logic [PTR_W-1:0] m;
      m = '0;
      s_next    = s_reg;
      s_next.rd = 1'b0;
      s_next.wr = 1'b0;
      if (s_reg.busy && mem_rvalid)
      begin
         s_next.acc  = mem_rdata;
         s_next.zero = (mem_rdata == 8'h00);
         s_next.busy = 1'b0;
      end
      if (take)
      begin
         if (is_ind || is_rel)
         begin
            // zero flag is left alone here; only the returned data sets it
            s_next.addr = ptr_ea;
            s_next.rd   = 1'b1;
            s_next.busy = 1'b1;
            if (is_ind)
               s_next.ptr[ptr_sel] = ptr_new;
         end
         else if (is_store)
         begin
            s_next.wr    = 1'b1;
            s_next.wdata = s_reg.acc;
            if (file_addr == FILE_IND0 || file_addr == FILE_IND1)
               s_next.addr = s_reg.ptr[file_addr[0]];
            else
               s_next.addr = {{(PTR_W-BANK_W-FILE_W){1'b0}}, s_reg.bank, file_addr};
         end
         else if (is_bank)
            s_next.bank = {1'b0, inst_word[3:0]};
         else if (is_page)
            s_next.page = inst_word[6:0];
         else if (is_lacc)
            s_next.acc = inst_word[7:0];
      end
      // software writes land after the instruction and so win a clash
      if (regs.wr_en)
      begin
         unique case (regs.wr_index)
            REG_BANK:
            begin
               m = merge({{(PTR_W-BANK_W){1'b0}}, s_reg.bank}, regs.wr_data, regs.wr_strb);
               s_next.bank = m[BANK_W-1:0];
            end
            REG_PAGE:
            begin
               m = merge({{(PTR_W-PAGE_W){1'b0}}, s_reg.page}, regs.wr_data, regs.wr_strb);
               s_next.page = m[PAGE_W-1:0];
            end
            REG_PTR0: s_next.ptr[0] = merge(s_next.ptr[0], regs.wr_data, regs.wr_strb);
            REG_PTR1: s_next.ptr[1] = merge(s_next.ptr[1], regs.wr_data, regs.wr_strb);
            default:  m = '0;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_reg        <= '0;
         s_reg.acc    <= RST_ACC;
         s_reg.bank   <= RST_BANK;
         s_reg.page   <= RST_PAGE;
         s_reg.ptr[0] <= RST_PTR;
         s_reg.ptr[1] <= RST_PTR;
      end
      else
         s_reg <= s_next;
   end

   // outputs straight from state flops
   assign mem_addr   = s_reg.addr;
   assign mem_rd     = s_reg.rd;
   assign mem_wr     = s_reg.wr;
   assign mem_wdata  = s_reg.wdata;
   assign acc_out    = s_reg.acc;
   assign zero_flag  = s_reg.zero;
   assign bank_sel   = s_reg.bank;
   assign page_latch = s_reg.page;

   default clocking dmiu_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // load data and the zero flag follow the memory answer
   AST_LOAD_ACC: assert property (s_reg.busy && mem_rvalid |=>
      acc_out == $past(mem_rdata) && zero_flag == ($past(mem_rdata) == 8'h00))
      else $error("load data lost");

   // addresses of the four pointer modes
   AST_PRE_ADDR: assert property (take && is_ind && mode == MODE_PRE_INC |=>
      mem_rd && mem_addr == $past(ptr_cur) + 16'h0001) else $error("pre-inc address");
   AST_PREDEC_ADDR: assert property (take && is_ind && mode == MODE_PRE_DEC |=>
      mem_addr == $past(ptr_cur) - 16'h0001) else $error("pre-dec address");
   AST_POST_ADDR: assert property (take && is_ind && mode[1] |=>
      mem_rd && mem_addr == $past(ptr_cur)) else $error("post address");

   // pointer update, relative form and pre-increment wrap past the top end
   AST_PTR_STEP: assert property (take && is_ind && !regs.wr_en |=>
      s_reg.ptr[$past(ptr_sel)] == ($past(mode[0]) ? $past(ptr_cur) - 16'h0001
      : $past(ptr_cur) + 16'h0001)) else $error("pointer step");
   AST_REL_ADDR: assert property (take && is_rel && !regs.wr_en |=>
      mem_addr == $past(ptr_rel) && $stable(s_reg.ptr)) else $error("relative access");
   AST_WRAP: assert property (take && is_ind && mode == MODE_PRE_INC
      && ptr_cur == 16'hffff |=> mem_addr == 16'h0000) else $error("pointer wrap");

   // stores to the indirect port land at the pointer address
   AST_INDF: assert property (take && is_store && file_addr[6:1] == 6'h00 |=>
      mem_wr && mem_addr == $past(s_reg.ptr[file_addr[0]])) else $error("indirect port");

   // literal loads leave the zero flag alone
   AST_BANK: assert property (take && is_bank && !regs.wr_en |=>
      bank_sel == {1'b0, $past(inst_word[3:0])} && $stable(zero_flag)) else $error("bank load");
   AST_PAGE: assert property (take && is_page && !regs.wr_en |=>
      page_latch == $past(inst_word[6:0]) && $stable(zero_flag)) else $error("page load");
   AST_LACC: assert property (take && is_lacc |=>
      acc_out == $past(inst_word[7:0]) && $stable(zero_flag)) else $error("literal load");

   // the write pulse lasts one cycle unless a second store was taken right behind it
   AST_STORE: assert property (take && is_store |=>
      (mem_wr && mem_wdata == $past(acc_out) && inst_ready)
      ##1 (!mem_wr || $past(take && is_store))) else $error("store");

   // banked direct address and flag-free pointer stepping
   AST_BANKED: assert property (take && is_store && file_addr[6:1] != 6'h00 |=>
      mem_addr == {4'h0, $past(bank_sel), $past(file_addr)}) else $error("bank join");
   AST_NOFLAG: assert property (take && (is_ind || is_rel) |=> $stable(zero_flag))
      else $error("flag moved");
endmodule

// ### test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dmiu_pkg::*;
   logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic              s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic              s_axi_arready, s_axi_rvalid, s_axi_rready, inst_valid, inst_ready;
   logic              mem_rd, mem_wr, mem_rvalid, zero_flag;
   logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic [INST_W-1:0] inst_word;
   logic [PTR_W-1:0]  mem_addr;
   logic [7:0]        mem_wdata, mem_rdata, acc_out;
   logic [BANK_W-1:0] bank_sel;
   logic [PAGE_W-1:0] page_latch;
   logic [PTR_W-1:0]  ptr [2];
   int                error_cnt, check_count, seed;

   // free-running core clock
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   dmiu_core dmiu_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .inst_valid, .inst_word, .inst_ready,
      .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .mem_rvalid, .acc_out,
      .zero_flag, .bank_sel, .page_latch);

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask

   // a wait that ran out of its bound ends the run at once
   task automatic hang;
      error_cnt++;
      $display("MISMATCH bus_wait exp done got timeout");
      report_and_stop();
   endtask

   // bready is raised with the request; it is legal to hold it early
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      if (n >= 50) hang();
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n >= 50) hang();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk("reg_data", exp, d);
      chk("rresp", RESP_OKAY, r);
   endtask

   // one instruction, held for exactly the taking edge
   task automatic exec(input logic [13:0] w);
      @(posedge aclk);
      chk("inst_ready", 1'b1, inst_ready);
      inst_valid <= 1'b1;
      inst_word  <= w;
      @(posedge aclk);
      inst_valid <= 1'b0;
      inst_word  <= 14'($random(seed));
      #1;
   endtask

   function automatic logic [15:0] ind_addr(input logic [15:0] p, input logic [1:0] m);
      return (m == 2'h0) ? p + 16'h1 : (m == 2'h1) ? p - 16'h1 : p;
   endfunction

   function automatic logic [15:0] ind_next(input logic [15:0] p, input logic [1:0] m);
      return m[0] ? p - 16'h1 : p + 16'h1;
   endfunction

   // memory answers promptly or one cycle late; data bus scrambled otherwise
   task automatic ind(input logic [13:0] w, input logic [15:0] ea, input logic [7:0] d);
      exec(w);
      chk("mem_rd", 1'b1, mem_rd);
      chk("mem_addr", ea, mem_addr);
      chk("inst_ready", 1'b0, inst_ready);
      repeat ($random(seed) & 1) @(posedge aclk);
      @(posedge aclk);
      mem_rvalid <= 1'b1;
      mem_rdata  <= d;
      @(posedge aclk);
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~d;
      #1;
      chk("acc", d, acc_out);
      chk("zero", d == 8'h00, zero_flag);
   endtask

   task automatic load(input logic n, input logic [1:0] m, input logic [7:0] d);
      ind({11'h002, n, m}, ind_addr(ptr[n], m), d);
      ptr[n] = ind_next(ptr[n], m);
   endtask

   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  k;
      logic [6:0]  f;
      seed = 32'h8542c1b3;
      {error_cnt, check_count} = '0;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, inst_valid, mem_rvalid, s_axi_wstrb, mem_rdata} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, inst_word} = '0;
      ptr[0] = 16'h0000;
      ptr[1] = 16'hffff;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      // reset values, unmapped and read-only places
      for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
      axi_rd(8'h18, d, r);
      chk("rresp", RESP_SLVERR, r);
      chk("rdata", 32'h0, d);
      axi_wr(8'h1c, 32'hffffffff, r);
      chk("bresp", RESP_SLVERR, r);
      axi_wr(8'h00, 32'h77, r);
      chk("bresp", RESP_OKAY, r);
      rd_chk(8'h00, 32'h0);
      axi_wr(8'h08, 32'h1f, r);
      rd_chk(8'h08, 32'h1f);
      axi_wr(8'h08, 32'h0, r);
      $display("test reset_and_bus done");
      // literals, extremes first; flags must not move
      for (int i = 0; i < 10; i++)
      begin
         k = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         exec({6'h30, k});
         chk("acc", k, acc_out);
         exec({9'h001, 1'b0, k[3:0]});
         chk("bank", {1'b0, k[3:0]}, bank_sel);
         exec({7'h63, k[6:0]});
         chk("page", k[6:0], page_latch);
         chk("zero", 1'b0, zero_flag);
      end
      $display("test literals done");
      // pointers at both ends so every mode crosses the wrap
      axi_wr(8'h14, 32'hffff, r);
      for (int n = 0; n < 2; n++)
         for (int m = 3; m >= 0; m--) load(1'(n), 2'(m), (m == 1) ? 8'h00 : 8'h81);
      for (int i = 0; i < 8; i++) load(1'($random(seed)), 2'($random(seed)), 8'($random(seed)));
      rd_chk(8'h10, {16'h0, ptr[0]});
      rd_chk(8'h14, {16'h0, ptr[1]});
      $display("test indirect done");
      // relative offset at both limits, pointer left alone
      for (int i = 0; i < 4; i++)
      begin
         k = (i == 0) ? 8'h20 : (i == 1) ? 8'h1f : 8'($random(seed));
         ind({7'h7e, i[0], k[5:0]}, ptr[i[0]] + {{10{k[5]}}, k[5:0]}, 8'(i + 1));
      end
      rd_chk(8'h10, {16'h0, ptr[0]});
      rd_chk(8'h14, {16'h0, ptr[1]});
      $display("test relative done");
      // stores with zero flag set; files 0 and 1 go through the pointers
      load(1'b0, MODE_POST_INC, 8'h00);
      exec({6'h30, 8'h5a});
      chk("zero", 1'b1, zero_flag);
      exec({9'h001, 5'h09});
      for (int i = 0; i < 8; i++)
      begin
         f = (i < 2) ? 7'(i) : 7'($random(seed));
         exec({7'h01, f});
         chk("mem_wr", 1'b1, mem_wr);
         chk("mem_wdata", 8'h5a, mem_wdata);
         chk("mem_addr", (f < 2) ? ptr[f[0]] : {4'h0, 5'h09, f}, mem_addr);
         chk("zero", 1'b1, zero_flag);
      end
      rd_chk(8'h04, 32'h1);
      rd_chk(8'h00, 32'h5a);
      $display("test store done");
      report_and_stop();
   end
endmodule
